// file: design/srs_pkg.sv
/*
  Package for the reference-period timer and sync/pulse sequencer.
  Holds register offsets, field positions, timing counts, state encoding
  and the control carrier struct. Assumes nothing of its surroundings.
*/
package srs_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] SRS_ALARM_STATUS_OFS = 8'h7D;
  localparam int SRS_VALID_BIT = 2;
  localparam logic [7:0] SRS_STATUS_RESET = 8'h00;

  // ------------------------------------------------------------------
  // Geometry and timing
  // ------------------------------------------------------------------
  localparam int SRS_PERIOD_W = 12;
  localparam int SRS_CHANNELS = 14;
  localparam int SRS_PAIRS = 7;
  localparam int SRS_START_LAT = 4;      // VCO cycles, start to stream
  localparam int SRS_SETTLE_PERIODS = 6; // timer periods before valid
  localparam int SRS_PULSE_W = 8;

  // ------------------------------------------------------------------
  // Sequencer states, Gray coded along the usual path
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRS_IDLE = 3'h0,
    SRS_ENABLE = 3'h1,
    SRS_RESET = 3'h3,
    SRS_START = 3'h2,
    SRS_RUN = 3'h6,
    SRS_DISABLE = 3'h4
  } srs_state_t;

  // Divider control bundle sent to every channel
  typedef struct packed {
    logic enable;
    logic reset;
    logic start;
  } srs_ctrl_t;

endpackage

// file: design/srs_sequencer.sv
/*
  Reference-period timer, sync/pulse sequence state machine, per-pair
  sync retiming, valid indication and status register read port.
  Assumes clk_i is the VCO-derived clock, all inputs are synchronous to
  it, and the divider channels own their own dividers and phase offsets.
*/
// Contract
// R1 - 12-bit programmed period sets the timer
// R2 - Requests sequence enable, reset, start, disable
// R3 - Host keeps timer rate at most 4 MHz
// R4 - Stream length counted in timer periods
// R5 - Stream starts fixed cycles after start phase
// R6 - Stop forces channel low combinationally
// R7 - Host limits phase offset to half minus eight
// R8 - Host adds delay above 3 GHz fanout
// R9 - Fourteen channels, seven pairs share retime flop
// R10 - Valid raised once outputs are settled
// R11 - Valid on output pin and status bit
// R12 - Valid clears whenever state not ready
// R13 - Tick at period, reload, machine advances
`timescale 1ns/100ps
`default_nettype none
module srs_sequencer
  import srs_pkg::*;
#(
  parameter int PULSE_W = SRS_PULSE_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [SRS_PERIOD_W-1:0] ref_period_count_i,
  input wire logic sync_req_i,
  input wire logic pulse_req_i,
  input wire logic [PULSE_W-1:0] pulse_periods_i,
  input wire logic [SRS_CHANNELS-1:0] pg_mask_i,
  input wire logic [SRS_CHANNELS-1:0] ch_div_i,
  input wire logic [7:0] reg_addr_i,
  output logic [7:0] reg_rdata_o,
  output logic general_output_pin_o,
  output logic [SRS_CHANNELS-1:0] div_enable_o,
  output logic [SRS_CHANNELS-1:0] div_reset_o,
  output logic [SRS_CHANNELS-1:0] div_start_o,
  output logic [SRS_CHANNELS-1:0] ch_out_o
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (PULSE_W < 1 || PULSE_W > 16) begin : g_bad_w
    $error("PULSE_W out of range");
  end

  // ------------------------------------------------------------------
  // Reference-period timer
  // ------------------------------------------------------------------
  logic [SRS_PERIOD_W-1:0] cnt_q, cnt_d;
  logic tick;

  // R13 tick and reload; passing the period reloads too,
  // so a lowered period never waits for a full 12-bit wrap
  assign tick = (cnt_q >= ref_period_count_i);
  // R1 programmed period length
  assign cnt_d = tick ? '0 : cnt_q + 1'b1;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end

  // ------------------------------------------------------------------
  // Sequence state machine
  // ------------------------------------------------------------------
  srs_state_t state_q, state_d;
  logic pulse_mode_q, pulse_mode_d;
  logic [2:0] lat_q, lat_d;
  logic [PULSE_W-1:0] run_q, run_d;
  logic req;
  logic lat_done;
  logic run_done;

  assign req = sync_req_i | pulse_req_i;
  // R5 fixed start latency
  assign lat_done = (lat_q == 3'(SRS_START_LAT - 1));
  // R4 length in timer periods; a sync alone runs zero periods
  assign run_done = !pulse_mode_q || (run_q == pulse_periods_i);

  // R2 enable, reset, start, disable in order
  always_comb begin
    state_d = state_q;
    case (state_q)
      SRS_IDLE: if (req) state_d = SRS_ENABLE;
      SRS_ENABLE: if (tick) state_d = SRS_RESET;
      SRS_RESET: if (tick) state_d = SRS_START;
      SRS_START: if (lat_done) state_d = SRS_RUN;
      SRS_RUN: if (tick && run_done) state_d = SRS_DISABLE;
      SRS_DISABLE: if (tick) state_d = SRS_IDLE;
      default: state_d = SRS_IDLE;
    endcase
  end

  // Request kind is latched at acceptance; requests outside idle are ignored, not held
  assign pulse_mode_d = (state_q == SRS_IDLE && req) ? pulse_req_i : pulse_mode_q;
  assign lat_d = (state_q == SRS_START) ? lat_q + 3'h1 : 3'h0;
  // R4 count periods while streaming
  assign run_d = (state_q != SRS_RUN) ? '0 : (tick ? run_q + 1'b1 : run_q);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= SRS_IDLE;
      pulse_mode_q <= 1'b0;
      lat_q <= 3'h0;
      run_q <= '0;
    end else begin
      state_q <= state_d;
      pulse_mode_q <= pulse_mode_d;
      lat_q <= lat_d;
      run_q <= run_d;
    end
  end

  // ------------------------------------------------------------------
  // Divider control and per-pair sync retiming
  // ------------------------------------------------------------------
  srs_ctrl_t ctl_q, ctl_d;
  logic [SRS_PAIRS-1:0] pair_q;

  assign ctl_d.enable = (state_d != SRS_IDLE);
  assign ctl_d.reset = (state_d == SRS_RESET);
  assign ctl_d.start = (state_d == SRS_RUN);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) ctl_q <= '0;
    else ctl_q <= ctl_d;
  end

  // R9 one retime flop per channel pair
  for (genvar p = 0; p < SRS_PAIRS; p++) begin : g_pair
    always_ff @(posedge clk_i) begin
      if (!rstn_i) pair_q[p] <= 1'b0;
      else pair_q[p] <= ctl_d.reset;
    end
    assign div_reset_o[2*p] = pair_q[p];
    assign div_reset_o[2*p+1] = pair_q[p];
  end

  assign div_enable_o = {SRS_CHANNELS{ctl_q.enable}};
  assign div_start_o = {SRS_CHANNELS{ctl_q.start}};

  // ------------------------------------------------------------------
  // Pulse stream gate
  // ------------------------------------------------------------------
  logic stream_on;

  // R6 no retime flop; a high level cut here may leave a runt pulse
  assign stream_on = (state_q == SRS_RUN);
  assign ch_out_o = (ch_div_i & ~pg_mask_i) | (ch_div_i & pg_mask_i & {SRS_CHANNELS{stream_on}});

  // ------------------------------------------------------------------
  // Valid indication and status register
  // ------------------------------------------------------------------
  logic synced_q, synced_d;
  logic [2:0] settle_q, settle_d;
  logic valid_q, valid_d;
  logic [7:0] rdata_d;
  logic pin_q;
  logic settled;

  assign synced_d = (state_q == SRS_DISABLE && tick && !pulse_mode_q) ? 1'b1 : synced_q;
  assign settled = (settle_q == 3'(SRS_SETTLE_PERIODS));
  assign settle_d = (state_q != SRS_IDLE || req) ? 3'h0 :
                    ((tick && !settled) ? settle_q + 3'h1 : settle_q);
  // R10 raised after settle time
  // R12 cleared as soon as anything is in flight
  assign valid_d = synced_q && settled && state_q == SRS_IDLE && !req;
  // R11 status bit, other bits read zero
  assign rdata_d = (reg_addr_i == SRS_ALARM_STATUS_OFS) ?
                   (8'h00 | (8'(valid_q) << SRS_VALID_BIT)) : 8'h00;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      synced_q <= 1'b0;
      settle_q <= 3'h0;
      valid_q <= 1'b0;
      reg_rdata_o <= SRS_STATUS_RESET;
      pin_q <= 1'b0;
    end else begin
      synced_q <= synced_d;
      settle_q <= settle_d;
      valid_q <= valid_d;
      reg_rdata_o <= rdata_d;
      pin_q <= valid_q;
    end
  end

  // R11 routed to the general output pin
  assign general_output_pin_o = pin_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  tick_period_a: assert property (tick |=> cnt_q == '0) // R13
    else $error("timer did not reload after tick");
  timer_count_a: assert property (!tick |=> cnt_q == $past(cnt_q) + 1'b1) // R1
    else $error("timer did not count");
  seq_order_a: assert property (state_q == SRS_ENABLE && tick |=> state_q == SRS_RESET ##1 !tick [*1]) // R2
    else $error("enable not followed by reset");
  start_latency_a: assert property ($rose(state_q == SRS_START) |-> ##4 state_q == SRS_RUN) // R5
    else $error("start latency not constant");
  stop_force_a: assert property (state_q != SRS_RUN |-> (ch_out_o & pg_mask_i) == '0) // R6
    else $error("pulse channel not forced low");
  pulse_len_a: assert property (state_q == SRS_RUN && tick && pulse_mode_q && run_q != pulse_periods_i
                                |=> state_q == SRS_RUN) // R4
    else $error("stream stopped early");
  pair_share_a: assert property (div_reset_o == {SRS_CHANNELS{state_q == SRS_RESET}}) // R9
    else $error("pair resets not aligned with reset phase");
  valid_clear_a: assert property (state_q != SRS_IDLE |=> !valid_q) // R12
    else $error("valid high while busy");
  valid_set_a: assert property (synced_q && settled && state_q == SRS_IDLE && !req |=> valid_q) // R10
    else $error("valid not raised when settled");
  flag_read_a: assert property (reg_addr_i == SRS_ALARM_STATUS_OFS |=>
                                reg_rdata_o[SRS_VALID_BIT] == $past(valid_q)) // R11
    else $error("status bit does not show valid");

  sync_seen_c: cover property (state_q == SRS_DISABLE && !pulse_mode_q ##1 state_q == SRS_IDLE);
  pulse_seen_c: cover property (state_q == SRS_RUN && pulse_mode_q && tick);
  valid_seen_c: cover property ($rose(valid_q));

endmodule
`default_nettype wire

// file: testbench/srs_div_model.sv
/*
  Model of the output divider channels fed by the sequencer.
  Assumes div resets arrive registered on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module srs_div_model
  import srs_pkg::*;
(
  input wire logic clk_i,
  input wire logic [SRS_CHANNELS-1:0] rst_i,
  output var logic [SRS_CHANNELS-1:0] div_o = '0
);
  logic [2:0] cnt_q [SRS_CHANNELS] = '{default: 3'h0};
  // modelled below 3 GHz, so no added delay
  always @(posedge clk_i) begin
    for (int i = 0; i < SRS_CHANNELS; i++) begin
      if (rst_i[i]) begin
        cnt_q[i] <= 3'h0;
        div_o[i] <= 1'b0;
      end else if (cnt_q[i] == 3'(i % 4)) begin
        cnt_q[i] <= 3'h0;
        div_o[i] <= ~div_o[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/sysref_sync_pulse_sequencer_tb.sv
/*
  Testbench: sync and pulse sequences, valid flag, status read.
  Assumes the divider model closes the channel loop.
*/
`timescale 1ns/100ps
`default_nettype none
module sysref_sync_pulse_sequencer_tb;
  import srs_pkg::*;
  logic clk_i = 0, rstn_i = 0, sync_req_i = 0, pulse_req_i = 0;
  logic [11:0] per = 12'h018;
  logic [7:0] pp = 8'h00, addr = 8'h00, rdata;
  logic [13:0] pg = '0, chd, en, rs, st, cho;
  logic pin, st0, rs0, en0;
  int fails = 0, comparisons = 0, cyc = 0, p, n;
  // Expected stream lengths in timer periods, one per request
  int exp_q[$];
  assign st0 = st[0];
  assign rs0 = rs[0];
  assign en0 = en[0];
  srs_sequencer srs_sequencer_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .ref_period_count_i(per), .sync_req_i(sync_req_i),
    .pulse_req_i(pulse_req_i), .pulse_periods_i(pp), .pg_mask_i(pg),
    .ch_div_i(chd), .reg_addr_i(addr), .reg_rdata_o(rdata),
    .general_output_pin_o(pin), .div_enable_o(en), .div_reset_o(rs),
    .div_start_o(st), .ch_out_o(cho));
  srs_div_model srs_div_model_i (.clk_i(clk_i), .rst_i(rs), .div_o(chd));
  initial forever #5 clk_i = ~clk_i;
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for a level, returns cycles spent
  task automatic wait_lv(ref logic s, input logic v, output int t);
    t = 0;
    while (s !== v && t < 2000) begin
      @(posedge clk_i);
      #1 t++;
    end
  endtask
  task automatic run_seq(input bit pulse, input int runs);
    int t, lat, hi, r;
    @(posedge clk_i);
    if (pulse) pulse_req_i <= 1'b1;
    else sync_req_i <= 1'b1;
    exp_q.push_back(runs);
    @(posedge clk_i);
    sync_req_i <= 1'b0;
    pulse_req_i <= 1'b0;
    #1 check(en, 14'h3FFF);
    @(posedge clk_i);
    #1 check({13'h0000, pin}, 14'h0000);
    wait_lv(rs0, 1'b1, t);
    check(rs, 14'h3FFF);
    wait_lv(rs0, 1'b0, t);
    wait_lv(st0, 1'b1, lat);
    check(14'(lat), 14'(SRS_START_LAT));
    wait_lv(st0, 1'b0, hi);
    r = exp_q.pop_front();
    check(14'(hi), 14'(p - SRS_START_LAT + r * p));
    wait_lv(en0, 1'b0, t);
    check({13'h0000, t <= p + 1}, 14'h0001);
  endtask
  // pulse channels are forced low outside the run
  always @(negedge clk_i) if (rstn_i) check(cho, (chd & ~pg) | (chd & pg & {14{st0}}));
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    int t;
    void'($urandom(40140));
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    addr <= 8'h7D;
    @(posedge clk_i);
    #1 check({6'h00, rdata}, 14'h0000);
    for (int k = 0; k < 4; k++) begin
      // timer rate kept at 4 MHz or below
      @(posedge clk_i);
      per <= 12'(24 + $urandom % 16);
      pp <= 8'($urandom % 3);
      pg <= 14'($urandom);
      @(posedge clk_i);
      p = per + 1;
      n = pp;
      run_seq(1'b0, 0);
      wait_lv(pin, 1'b1, t);
      check({13'h0000, t >= 5 * p && t <= 7 * p + 3}, 14'h0001);
      @(posedge clk_i);
      #1 check({6'h00, rdata}, 14'h0004);
      @(posedge clk_i);
      addr <= 8'h00;
      repeat (2) @(posedge clk_i);
      #1 check({6'h00, rdata}, 14'h0000);
      @(posedge clk_i);
      addr <= 8'h7D;
      run_seq(1'b1, n);
      wait_lv(pin, 1'b1, t);
      check({13'h0000, pin}, 14'h0001);
      $display("test %0d done", k);
    end
    test_done();
  end
endmodule
`default_nettype wire
